// >>> hw/irq_prio_pkg.sv
// Constants, types and register map of the interrupt priority bank
//
// Overview of operation
// - Code 111 is level 7, codes map linearly
// - Code 001 is level 1, 000 disables
// - Sync serial event level: word2 bits 10-8
// - Timer c level: word2 bits 2-0
// - Two-wire master level: word4 bits 6-4
// - Two-wire slave level: word4 bits 2-0
// - Only enabled sources reach arbitration
// - Sources with flag clear are never presented
package irq_prio_pkg;

	// ****************************************************************
	// Sizes and level codes
	// ****************************************************************
	localparam int NUM_SRC   = 16;
	localparam int NUM_WORDS = 5;
	localparam int LEVEL_W   = 3;

	typedef logic [LEVEL_W-1:0] level_t;

	localparam level_t LEVEL_OFF = 3'h0;
	localparam level_t LEVEL_MIN = 3'h1;
	localparam level_t LEVEL_MAX = 3'h7;
	localparam level_t LEVEL_RST = 3'h4;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [31:0] OFF_WORD0 = 32'h0000_0000;
	localparam logic [31:0] OFF_WORD1 = 32'h0000_0004;
	localparam logic [31:0] OFF_WORD2 = 32'h0000_0008;
	localparam logic [31:0] OFF_WORD3 = 32'h0000_000C;
	localparam logic [31:0] OFF_WORD4 = 32'h0000_0010;

	// ****************************************************************
	// Implemented bit masks and reset values
	// ****************************************************************
	localparam logic [15:0] MASK_WORD0 = 16'h7777;
	localparam logic [15:0] MASK_WORD1 = 16'h7770;
	localparam logic [15:0] MASK_WORD2 = 16'h7777;
	localparam logic [15:0] MASK_WORD3 = 16'h0077;
	localparam logic [15:0] MASK_WORD4 = 16'h7077;

	localparam logic [15:0] RST_WORD0 = 16'h4444;
	localparam logic [15:0] RST_WORD1 = 16'h4440;
	localparam logic [15:0] RST_WORD2 = 16'h4444;
	localparam logic [15:0] RST_WORD3 = 16'h0044;
	localparam logic [15:0] RST_WORD4 = 16'h4044;

	// ****************************************************************
	// Field positions (low bit) within their words
	// ****************************************************************
	localparam int TIMER_A_LSB      = 12;
	localparam int COMPARE_A_LSB    = 8;
	localparam int CAPTURE_A_LSB    = 4;
	localparam int EXT_LINE_A_LSB   = 0;
	localparam int TIMER_B_LSB      = 12;
	localparam int COMPARE_B_LSB    = 8;
	localparam int CAPTURE_B_LSB    = 4;
	localparam int SERIAL_RX_LSB    = 12;
	localparam int SS_EVENT_LSB     = 8;
	localparam int SS_ERROR_LSB     = 4;
	localparam int TIMER_C_LSB      = 0;
	localparam int CONV_DONE_LSB    = 4;
	localparam int SERIAL_TX_LSB    = 0;
	localparam int PIN_CHANGE_LSB   = 12;
	localparam int TW_MASTER_LSB    = 4;
	localparam int TW_SLAVE_LSB     = 0;

	// ****************************************************************
	// Per-source levels; source 0 sits in the low bits
	// ****************************************************************
	typedef struct packed {
		level_t two_wire_slave_level;
		level_t two_wire_master_level;
		level_t pin_change_level;
		level_t serial_tx_level;
		level_t converter_done_level;
		level_t timer_c_level;
		level_t sync_serial_error_level;
		level_t sync_serial_event_level;
		level_t serial_rx_level;
		level_t capture_b_level;
		level_t compare_b_level;
		level_t timer_b_level;
		level_t ext_line_a_level;
		level_t capture_a_level;
		level_t compare_a_level;
		level_t timer_a_level;
	} levels_t;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// >>> hw/irq_priority_field_bank.sv
// Interrupt priority field bank with AHB-Lite register access
`timescale 1ns/100ps
module irq_priority_field_bank (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  arst_n_i,
	// AHB-Lite slave
	input  wire logic                  hsel_i,
	input  wire logic [31:0]           haddr_i,
	input  wire logic [1:0]            htrans_i,
	input  wire logic                  hwrite_i,
	input  wire logic [2:0]            hsize_i,
	input  wire logic [31:0]           hwdata_i,
	input  wire logic                  hready_i,
	output logic      [31:0]           hrdata_o,
	output logic                       hreadyout_o,
	output logic                       hresp_o,
	// Per-source flag and enable
	input  wire logic [15:0]           flag_i,
	input  wire logic [15:0]           enable_i,
	// Levels toward arbitration
	output irq_prio_pkg::levels_t      prog_levels_o,
	output irq_prio_pkg::levels_t      req_levels_o,
	output logic      [15:0]           req_o
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic addr_hit(input logic [31:0] a);
		addr_hit = (a == irq_prio_pkg::OFF_WORD0) ||
			(a == irq_prio_pkg::OFF_WORD1) ||
			(a == irq_prio_pkg::OFF_WORD2) ||
			(a == irq_prio_pkg::OFF_WORD3) ||
			(a == irq_prio_pkg::OFF_WORD4);
	endfunction

	function automatic logic [2:0] addr_idx(input logic [31:0] a);
		addr_idx = a[4:2];
	endfunction

	function automatic logic [15:0] word_mask(input logic [2:0] i);
		unique case (i)
			3'h0:    word_mask = irq_prio_pkg::MASK_WORD0;
			3'h1:    word_mask = irq_prio_pkg::MASK_WORD1;
			3'h2:    word_mask = irq_prio_pkg::MASK_WORD2;
			3'h3:    word_mask = irq_prio_pkg::MASK_WORD3;
			3'h4:    word_mask = irq_prio_pkg::MASK_WORD4;
			default: word_mask = 16'h0000;
		endcase
	endfunction

	// ****************************************************************
	// Bus address phase capture and register bank
	// ****************************************************************
	logic [4:0][15:0] bank_reg;
	logic [4:0][15:0] bank_next;
	logic             wr_pend_reg;
	logic             wr_pend_next;
	logic [2:0]       wr_idx_reg;
	logic [2:0]       wr_idx_next;
	logic [15:0]      rdata_reg;
	logic [15:0]      rdata_next;
	logic             addr_ok;
	logic             rd_ok;

	always_comb begin
		addr_ok = hsel_i && hready_i &&
			(htrans_i == irq_prio_pkg::HTRANS_NONSEQ);
		rd_ok = addr_ok && !hwrite_i && addr_hit(haddr_i);
		wr_pend_next = wr_pend_reg;
		wr_idx_next = wr_idx_reg;
		bank_next = bank_reg;
		rdata_next = rdata_reg;
		if (hready_i) begin
			wr_pend_next = addr_ok && hwrite_i && addr_hit(haddr_i);
			wr_idx_next = addr_idx(haddr_i);
		end
		if (wr_pend_reg && hready_i) begin
			// Unimplemented positions never store
			bank_next[wr_idx_reg] = hwdata_i[15:0] &
				word_mask(wr_idx_reg);
		end
		if (addr_ok && !hwrite_i) begin
			// Forward a write in its data phase to a following read
			rdata_next = rd_ok ? bank_next[addr_idx(haddr_i)] : 16'h0000;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bank_reg[0] <= irq_prio_pkg::RST_WORD0;
			bank_reg[1] <= irq_prio_pkg::RST_WORD1;
			bank_reg[2] <= irq_prio_pkg::RST_WORD2;
			bank_reg[3] <= irq_prio_pkg::RST_WORD3;
			bank_reg[4] <= irq_prio_pkg::RST_WORD4;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 3'h0;
			rdata_reg <= 16'h0000;
		end else begin
			bank_reg <= bank_next;
			wr_pend_reg <= wr_pend_next;
			wr_idx_reg <= wr_idx_next;
			rdata_reg <= rdata_next;
		end
	end

	assign hrdata_o = {16'h0000, rdata_reg};
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// ****************************************************************
	// Field extraction
	// ****************************************************************
	irq_prio_pkg::levels_t levels;

	always_comb begin
		levels.timer_a_level =
			bank_reg[0][irq_prio_pkg::TIMER_A_LSB +: 3];
		levels.compare_a_level =
			bank_reg[0][irq_prio_pkg::COMPARE_A_LSB +: 3];
		levels.capture_a_level =
			bank_reg[0][irq_prio_pkg::CAPTURE_A_LSB +: 3];
		levels.ext_line_a_level =
			bank_reg[0][irq_prio_pkg::EXT_LINE_A_LSB +: 3];
		levels.timer_b_level =
			bank_reg[1][irq_prio_pkg::TIMER_B_LSB +: 3];
		levels.compare_b_level =
			bank_reg[1][irq_prio_pkg::COMPARE_B_LSB +: 3];
		levels.capture_b_level =
			bank_reg[1][irq_prio_pkg::CAPTURE_B_LSB +: 3];
		levels.serial_rx_level =
			bank_reg[2][irq_prio_pkg::SERIAL_RX_LSB +: 3];
		levels.sync_serial_event_level =
			bank_reg[2][irq_prio_pkg::SS_EVENT_LSB +: 3];
		levels.sync_serial_error_level =
			bank_reg[2][irq_prio_pkg::SS_ERROR_LSB +: 3];
		levels.timer_c_level =
			bank_reg[2][irq_prio_pkg::TIMER_C_LSB +: 3];
		levels.converter_done_level =
			bank_reg[3][irq_prio_pkg::CONV_DONE_LSB +: 3];
		levels.serial_tx_level =
			bank_reg[3][irq_prio_pkg::SERIAL_TX_LSB +: 3];
		levels.pin_change_level =
			bank_reg[4][irq_prio_pkg::PIN_CHANGE_LSB +: 3];
		levels.two_wire_master_level =
			bank_reg[4][irq_prio_pkg::TW_MASTER_LSB +: 3];
		levels.two_wire_slave_level =
			bank_reg[4][irq_prio_pkg::TW_SLAVE_LSB +: 3];
	end

	assign prog_levels_o = levels;

	// ****************************************************************
	// Request gating toward arbitration
	// ****************************************************************
	logic [47:0] lv_flat;
	logic [47:0] gated_next;
	logic [15:0] req_next;
	logic [47:0] gated_reg;
	logic [15:0] req_reg;

	always_comb begin
		lv_flat = levels;
		gated_next = 48'h0000_0000_0000;
		req_next = 16'h0000;
		for (int k = 0; k < irq_prio_pkg::NUM_SRC; k++) begin
			// Code 000 is off; any other code is its own level
			req_next[k] = flag_i[k] && enable_i[k] &&
				(lv_flat[3*k +: 3] != irq_prio_pkg::LEVEL_OFF);
			gated_next[3*k +: 3] = req_next[k] ?
				lv_flat[3*k +: 3] : irq_prio_pkg::LEVEL_OFF;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gated_reg <= 48'h0000_0000_0000;
			req_reg <= 16'h0000;
		end else begin
			gated_reg <= gated_next;
			req_reg <= req_next;
		end
	end

	assign req_levels_o = irq_prio_pkg::levels_t'(gated_reg);
	assign req_o = req_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	sequence wr_word2_s;
		(hsel_i && hready_i && hwrite_i &&
			htrans_i == irq_prio_pkg::HTRANS_NONSEQ &&
			haddr_i == irq_prio_pkg::OFF_WORD2) ##1 hready_i;
	endsequence

	sequence rd_word4_s;
		hsel_i && hready_i && !hwrite_i &&
			htrans_i == irq_prio_pkg::HTRANS_NONSEQ &&
			haddr_i == irq_prio_pkg::OFF_WORD4 && !wr_pend_reg;
	endsequence

	sequence wr_word4_s;
		(hsel_i && hready_i && hwrite_i &&
			htrans_i == irq_prio_pkg::HTRANS_NONSEQ &&
			haddr_i == irq_prio_pkg::OFF_WORD4) ##1 hready_i;
	endsequence

	sequence rd_unmapped_s;
		hsel_i && hready_i && !hwrite_i &&
			htrans_i == irq_prio_pkg::HTRANS_NONSEQ &&
			!addr_hit(haddr_i);
	endsequence

	level_max_a: assert property (flag_i[0] && enable_i[0] &&
		levels.timer_a_level == irq_prio_pkg::LEVEL_MAX |=>
		req_levels_o.timer_a_level == 3'h7 && req_o[0])
		else $error("level 7 not presented");

	level_off_a: assert property (
		levels.ext_line_a_level == irq_prio_pkg::LEVEL_OFF |=>
		!req_o[3] && req_levels_o.ext_line_a_level == 3'h0)
		else $error("disabled source presented");

	level_min_a: assert property (flag_i[3] && enable_i[3] &&
		levels.ext_line_a_level == irq_prio_pkg::LEVEL_MIN |=>
		req_o[3] && req_levels_o.ext_line_a_level == 3'h1)
		else $error("level 1 not presented");

	ss_event_pos_a: assert property (wr_word2_s |=>
		levels.sync_serial_event_level == $past(hwdata_i[10:8]))
		else $error("sync serial event field misplaced");

	timer_c_pos_a: assert property (wr_word2_s |=>
		levels.timer_c_level == $past(hwdata_i[2:0]) &&
		bank_reg[2][3] == 1'b0)
		else $error("timer c field misplaced");

	tw_master_pos_a: assert property (rd_word4_s ##1 1'b1 |->
		hrdata_o[6:4] == $past(levels.two_wire_master_level) &&
		hrdata_o[11:7] == 5'h00)
		else $error("two-wire master field misread");

	tw_slave_gate_a: assert property (flag_i[15] && enable_i[15] |=>
		req_levels_o.two_wire_slave_level ==
		$past(bank_reg[4][2:0]))
		else $error("two-wire slave level wrong");

	enable_gate_a: assert property (!enable_i[10] |=>
		!req_o[10] && req_levels_o.timer_c_level == 3'h0)
		else $error("disabled source reached arbitration");

	flag_gate_a: assert property (!flag_i[8] |=>
		!req_o[8] && req_levels_o.sync_serial_event_level == 3'h0)
		else $error("idle source reached arbitration");

	unimpl_zero_a: assert property (
		(bank_reg[1] & ~irq_prio_pkg::MASK_WORD1) == 16'h0000 &&
		(bank_reg[3] & ~irq_prio_pkg::MASK_WORD3) == 16'h0000 &&
		(bank_reg[4] & ~irq_prio_pkg::MASK_WORD4) == 16'h0000)
		else $error("unimplemented bit stored");

	unimpl_low_a: assert property (
		(bank_reg[0] & ~irq_prio_pkg::MASK_WORD0) == 16'h0000 &&
		(bank_reg[2] & ~irq_prio_pkg::MASK_WORD2) == 16'h0000 &&
		hrdata_o[31:16] == 16'h0000)
		else $error("unimplemented bit visible");

	tw_slave_pos_a: assert property (wr_word4_s |=>
		levels.two_wire_slave_level == $past(hwdata_i[2:0]) &&
		levels.two_wire_master_level == $past(hwdata_i[6:4]))
		else $error("two-wire slave field misplaced");

	tw_master_gate_a: assert property (flag_i[14] && enable_i[14] &&
		levels.two_wire_master_level != irq_prio_pkg::LEVEL_OFF |=>
		req_o[14] && req_levels_o.two_wire_master_level ==
		$past(levels.two_wire_master_level))
		else $error("two-wire master level not presented");

	rx_level_a: assert property (flag_i[7] && enable_i[7] &&
		levels.serial_rx_level != irq_prio_pkg::LEVEL_OFF |=>
		req_levels_o.serial_rx_level == $past(levels.serial_rx_level))
		else $error("serial rx level not linear");

	req_subset_a: assert property (1'b1 |=>
		(req_o & ~$past(flag_i & enable_i)) == 16'h0000)
		else $error("request without flag and enable");

	unmapped_read_a: assert property (rd_unmapped_s |=>
		hrdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	bank_hold_a: assert property (!wr_pend_reg |=> $stable(bank_reg))
		else $error("register changed without a write");

	bus_okay_a: assert property (hresp_o == 1'b0 && hreadyout_o == 1'b1)
		else $error("bus response not okay");

endmodule

// >>> verif/prio_arbiter_model.sv
// Arbitration-side model: picks the highest requesting level
`timescale 1ns/100ps
module prio_arbiter_model (
	// Levels from the bank
	input  wire logic [47:0] req_levels_i,
	input  wire logic [15:0] req_i,
	// Winning level
	output logic      [2:0]  top_level_o
);
	always_comb begin
		top_level_o = 3'h0;
		for (int i = 0; i < 16; i++) begin
			if (req_i[i] && req_levels_i[3*i+:3] > top_level_o) begin
				top_level_o = req_levels_i[3*i+:3];
			end
		end
	end
endmodule

// >>> verif/tb_irq_priority_field_bank.sv
// Self-checking testbench of the interrupt priority bank
`timescale 1ns/100ps
module tb_irq_priority_field_bank;
	logic                  clk_i, arst_n_i, hsel, hwrite, hready, hresp;
	logic [1:0]            htrans;
	logic [31:0]           haddr, hwdata, hrdata, q;
	logic [15:0]           flag, enable, req;
	irq_prio_pkg::levels_t prog, rql;
	logic [2:0]            top;
	int                    miscompares, total_checks;
	logic [15:0]           mw [5];
	localparam int WI [16] = '{0,0,0,0,1,1,1,2,2,2,2,3,3,4,4,4};
	localparam int LS [16] = '{12,8,4,0,12,8,4,12,8,4,0,4,0,12,4,0};
	localparam logic [15:0] MK [5] = '{16'h7777, 16'h7770, 16'h7777,
		16'h0077, 16'h7077};
	localparam logic [15:0] RV [5] = '{16'h4444, 16'h4440, 16'h4444,
		16'h0044, 16'h4044};

	irq_priority_field_bank DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .flag_i(flag), .enable_i(enable),
		.prog_levels_o(prog), .req_levels_o(rql), .req_o(req));
	prio_arbiter_model PARTNER (.req_levels_i(rql), .req_i(req),
		.top_level_o(top));

	// ****************************************************************
	// Model and helpers
	// ****************************************************************
	function automatic logic [47:0] exp_prog();
		logic [47:0] r;
		for (int i = 0; i < 16; i++) r[3*i+:3] = mw[WI[i]][LS[i]+:3];
		return r;
	endfunction
	task automatic chk(input logic [47:0] g, input logic [47:0] e,
		input string m);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic edge_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (n >= 64) begin
			miscompares++;
			$display("MISMATCH %0t bus stall", $time);
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= irq_prio_pkg::HTRANS_NONSEQ;
		edge_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		q = hrdata;
		chk(48'(hresp), 48'h0, "response");
	endtask
	task automatic wr(input int w, input logic [15:0] d);
		ahb(1'b1, 32'(w * 4), {16'($urandom), d});
		mw[w] = d & MK[w];
	endtask
	task automatic rd(input int w);
		ahb(1'b0, 32'(w * 4), $urandom);
		chk(48'(q), 48'(mw[w]), "read");
	endtask
	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
		chk(prog, exp_prog(), "levels");
		@(posedge clk_i);
	endtask
	task automatic reqchk(input bit full, input int n);
		logic [15:0] f, e, er;
		logic [47:0] el, p;
		logic [2:0]  mx;
		repeat (n) begin
			f = full ? 16'hFFFF : 16'($urandom);
			e = full ? 16'hFFFF : 16'($urandom);
			flag <= f;
			enable <= e;
			@(posedge clk_i);
			#1;
			p = exp_prog();
			el = '0;
			mx = 3'h0;
			for (int i = 0; i < 16; i++) begin
				er[i] = f[i] && e[i] && p[3*i+:3] != 3'h0;
				if (er[i]) el[3*i+:3] = p[3*i+:3];
				if (er[i] && p[3*i+:3] > mx) mx = p[3*i+:3];
			end
			chk(48'(req), 48'(er), "request");
			chk(rql, el, "gated level");
			chk(48'(top), 48'(mx), "winner");
			@(posedge clk_i);
		end
	endtask

	// ****************************************************************
	// Clock, stimulus and watchdog
	// ****************************************************************
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#40000;
		miscompares++;
		$display("MISMATCH %0t watchdog", $time);
		results();
	end
	initial begin
		{arst_n_i, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{flag, enable, miscompares, total_checks} = '0;
		void'($urandom(32'h1887_04e4));
		for (int w = 0; w < 5; w++) mw[w] = RV[w];
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'b1;
		settle();
		ahb(1'b1, 32'h0000_0014, 32'hFFFF_FFFF);
		ahb(1'b1, 32'h0000_0002, 32'h0000_0000);
		for (int w = 0; w < 5; w++) rd(w);
		ahb(1'b0, 32'h0000_0014, 32'h0);
		chk(48'(q), 48'h0, "unmapped");
		ahb(1'b0, 32'h0000_0006, 32'h0);
		chk(48'(q), 48'h0, "misaligned");
		for (int w = 0; w < 5; w++) wr(w, 16'hFFFF);
		for (int w = 0; w < 5; w++) rd(w);
		for (int c = 0; c < 8; c++) begin
			wr(2, 16'(16'h1111 * c));
			rd(2);
			wr(4, 16'(16'h1111 * c));
			rd(4);
			settle();
			reqchk(1'b1, 2);
		end
		repeat (20) begin
			for (int w = 0; w < 5; w++) wr(w, 16'($urandom));
			settle();
			reqchk(1'b0, 8);
		end
		arst_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		chk(48'(req), 48'h0, "reset request");
		chk(rql, 48'h0, "reset level");
		for (int w = 0; w < 5; w++) mw[w] = RV[w];
		arst_n_i <= 1'b1;
		settle();
		reqchk(1'b1, 2);
		results();
	end
endmodule
